// [cpbcc_pkg.sv]
// Shared constants and types for the processor-to-expansion-bus command control block
package cpbcc_pkg;

    // =====================================================================
    // Wait-state counts
    // =====================================================================
    localparam logic [2:0] WAITS_ZERO    = 3'h0;
    localparam logic [2:0] WAITS_WIDE    = 3'h1;
    localparam logic [2:0] WAITS_NARROW  = 3'h4;

    // =====================================================================
    // Alternate address-line-20 gate port
    // =====================================================================
    localparam logic [15:0] ALT_GATE_PORT    = 16'h0092;
    localparam logic        ALT_GATE_RESET   = 1'h0;

    // =====================================================================
    // Reset values of the pin drivers
    // =====================================================================
    localparam logic STROBE_IDLE   = 1'h1;
    localparam logic ALE_IDLE      = 1'h0;
    localparam logic XCVR_IDLE     = 1'h1;
    localparam logic CMDBUF_IDLE   = 1'h1;
    localparam logic OE_RELEASED   = 1'h1;

    // Number of on-board devices that can claim I/O space
    localparam int ONBOARD_COUNT = 5;

    // =====================================================================
    // Bus cycle sequencer states
    // =====================================================================
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TS   = 2'b01,
        ST_TC   = 2'b10,
        ST_DONE = 2'b11
    } cpbcc_state_t;

    // Decoded processor cycle kinds
    typedef enum logic [2:0] {
        K_IACK  = 3'b000,
        K_IO_RD = 3'b001,
        K_IO_WR = 3'b010,
        K_MRD   = 3'b011,
        K_MWR   = 3'b100,
        K_HALT  = 3'b101,
        K_NONE  = 3'b110
    } cpbcc_kind_t;

endpackage : cpbcc_pkg

// [cpbcc_lane_decode.sv]
// Byte-lane decode from high-byte enable and latched address bit 0
`timescale 1ns/100ps
module cpbcc_lane_decode
    import cpbcc_pkg::*;
(
    input  wire logic highByteEnableN,   // Upper lane enable, active low
    input  wire logic addrBit0,          // Latched address bit 0
    output logic      wordXfer,          // Both lanes
    output logic      oddByte,           // Upper lane only
    output logic      evenByte           // Lower lane only
);

    // =====================================================================
    // Decode; both high is an unused combination and selects nothing
    // =====================================================================
    always_comb begin
        wordXfer = !highByteEnableN && !addrBit0;
        oddByte  = !highByteEnableN &&  addrBit0;
        evenByte =  highByteEnableN && !addrBit0;
    end

endmodule : cpbcc_lane_decode

// [cpbcc_bus_control.sv]
// Processor-to-expansion-bus command control: strobes, ready, buffer and bit 20 control
//
// Behaviour
// - Assert ready low when transfer completes.
// - Address strobe starts cycle; detects newer processor.
// - Drive I/O read and write strobes.
// - Drive memory read and write strobes.
// - External master: strobes, bit 0, bit 20 inputs.
// - Pulse interrupt acknowledge in acknowledge cycles.
// - Address latch strobe high in first state.
// - High-byte enable is input under processor control.
// - Decode byte enable and bit 0 lanes.
// - Bit 20 gated by keyboard gate, port 92.
// - Zero-wait input ends cycle without waits.
// - Wide selects give 16-bit one-wait cycle.
// - Command buffer enabled during DMA and refresh.
// - Buffer enabled for I/O except coprocessor hits and on-board claims.
// - Buffer enabled for memory except on-board video.
// - Drive transceiver direction control.
// - Direction low for reads, acknowledge, DMA memory.
`timescale 1ns/100ps
module cpbcc_bus_control
    import cpbcc_pkg::*;
(
    input  wire logic                     clk,                // 100 MHz clock
    input  wire logic                     rst,                // Async reset, active high
    input  wire logic                     ce,                 // Clock enable, freezes all state
    input  wire logic                     addrStrobeN,        // Processor address strobe
    input  wire logic                     memIoSel,           // 1 memory, 0 I/O
    input  wire logic                     dataCodeSel,        // 1 data, 0 code
    input  wire logic                     writeRead,          // 1 write, 0 read
    input  wire logic [15:0]              cpuAddrLow,         // Processor address 15..0
    input  wire logic                     cpuAddrBit20,       // Processor address bit 20
    input  wire logic                     cpuDataBit1,        // Processor data bit 1
    input  wire logic                     highByteEnableN,    // Upper lane enable
    input  wire logic                     kbcAddr20Gate,      // Keyboard controller bit 20 gate
    input  wire logic                     zeroWaitN,          // Zero-wait request
    input  wire logic                     ioWideSelectN,      // 16-bit I/O select
    input  wire logic                     memWideSelectN,     // 16-bit memory select
    input  wire logic                     ioChannelReady,     // Channel ready, low adds waits
    input  wire logic                     masterN,            // External master owns bus
    input  wire logic                     dmaActive,          // DMA address enable
    input  wire logic                     refreshN,           // Refresh cycle in progress
    input  wire logic                     coprocHit,          // Coprocessor I/O address
    input  wire logic [ONBOARD_COUNT-1:0] onboardEnable,      // Per on-board device
    input  wire logic [ONBOARD_COUNT-1:0] onboardIoHit,       // Matching I/O address hits
    input  wire logic                     videoEnabled,       // On-board video enabled
    input  wire logic                     videoRomHit,        // Specified video BIOS ROM hit
    input  wire logic                     videoRamHit,        // Specified video memory hit
    output logic                          sysReadyN,          // Ready to processor
    output logic                          sysReadyOeN,        // Ready driver enable
    input  wire logic                     ioReadCmdIn,        // I/O read pin level
    output logic                          ioReadCmdN,         // I/O read drive
    input  wire logic                     ioWriteCmdIn,       // I/O write pin level
    output logic                          ioWriteCmdN,        // I/O write drive
    input  wire logic                     memReadCmdIn,       // Memory read pin level
    output logic                          memReadCmdN,        // Memory read drive
    input  wire logic                     memWriteCmdIn,      // Memory write pin level
    output logic                          memWriteCmdN,       // Memory write drive
    output logic                          cmdOeN,             // Strobe drivers enable
    input  wire logic                     latchedAddrBit0In,  // Bit 0 pin level
    output logic                          latchedAddrBit0,    // Bit 0 drive
    output logic                          latchedAddrBit0OeN, // Bit 0 driver enable
    output logic                          addrBit20,          // Gated address bit 20 drive
    output logic                          addrBit20OeN,       // Bit 20 driver enable
    output logic                          intAckN,            // Interrupt acknowledge
    output logic                          addrLatchEnable,    // Address latch strobe
    output logic                          cmdBufferEnableN,   // Command buffer enable
    output logic                          xcvrDirection,      // 1 processor drives bus
    output logic                          wordXfer,           // Word transfer
    output logic                          oddByte,            // Upper byte transfer
    output logic                          evenByte,           // Lower byte transfer
    output logic                          masterCmdSeen,      // Master drives a command
    output logic                          newCpuPresent       // Strobe activity seen
);

    // =====================================================================
    // Declarations
    // =====================================================================
    cpbcc_state_t state_reg;
    cpbcc_state_t state_next;
    cpbcc_kind_t  kind_reg;
    cpbcc_kind_t  kindDecode;
    cpbcc_kind_t  kindSel;
    logic [2:0]   waitCnt_reg;
    logic [2:0]   waitLoad;
    logic         altGate_reg;
    logic         dmaPrev_reg;
    logic         refreshPrev_reg;
    logic         masterActive;
    logic         inCycle;
    logic         isMem;
    logic         isIo;
    logic         dmaMemCycle;
    logic         onboardClaim;
    logic         videoClaim;
    logic         laneBit0;
    logic         laneWord;
    logic         laneOdd;
    logic         laneEven;

    assign masterActive = !masterN;
    assign onboardClaim = |(onboardEnable & onboardIoHit);
    assign videoClaim   = videoEnabled && (videoRomHit || videoRamHit);
    assign dmaMemCycle  = dmaActive && (!memReadCmdIn || !memWriteCmdIn);

    // =====================================================================
    // Cycle kind from processor status
    // =====================================================================
    always_comb begin
        kindDecode = K_NONE;
        unique case ({memIoSel, dataCodeSel, writeRead})
            3'b000: kindDecode = K_IACK;
            3'b001: kindDecode = K_NONE;
            3'b010: kindDecode = K_IO_RD;
            3'b011: kindDecode = K_IO_WR;
            3'b100: kindDecode = K_MRD;
            3'b101: kindDecode = K_HALT;
            3'b110: kindDecode = K_MRD;
            3'b111: kindDecode = K_MWR;
        endcase
    end

    // Outputs must settle on the edge that enters the first state
    assign kindSel = (state_reg == ST_IDLE) ? kindDecode : kind_reg;
    assign isMem   = (kindSel == K_MRD) || (kindSel == K_MWR);
    assign isIo    = (kindSel == K_IO_RD) || (kindSel == K_IO_WR);
    assign inCycle = (state_next != ST_IDLE);

    // =====================================================================
    // Wait-state selection
    // =====================================================================
    always_comb begin
        waitLoad = WAITS_NARROW;
        if (!zeroWaitN) begin
            waitLoad = WAITS_ZERO;
        end else if ((!ioWideSelectN && isIo) || (!memWideSelectN && isMem)) begin
            waitLoad = WAITS_WIDE;
        end
    end

    // =====================================================================
    // Sequencer
    // =====================================================================
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (!masterActive && !addrStrobeN) begin
                    state_next = ST_TS;
                end
            end
            ST_TS: begin
                if ((kind_reg == K_HALT) || (kind_reg == K_NONE)) begin
                    state_next = ST_DONE;
                end else begin
                    state_next = ST_TC;
                end
            end
            ST_TC: begin
                // Zero-wait request may arrive late and still cut the cycle short
                if (!zeroWaitN) begin
                    state_next = ST_DONE;
                end else if ((waitCnt_reg == WAITS_ZERO) && ioChannelReady) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kind_reg <= K_NONE;
        end else if (ce && (state_reg == ST_IDLE) && (state_next == ST_TS)) begin
            kind_reg <= kindDecode;
        end
    end

    // The count runs down in the command state whatever channel ready does; ready low only holds the cycle once the count is zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_reg <= WAITS_ZERO;
        end else if (ce) begin
            if (state_reg == ST_TS) begin
                waitCnt_reg <= waitLoad;
            end else if ((state_reg == ST_TC) && (waitCnt_reg != WAITS_ZERO)) begin
                waitCnt_reg <= waitCnt_reg - 3'h1;
            end
        end
    end

    // =====================================================================
    // Ready and newer-processor detection
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysReadyN   <= STROBE_IDLE;
            sysReadyOeN <= OE_RELEASED;
        end else if (ce) begin
            sysReadyN   <= !(state_next == ST_DONE);
            sysReadyOeN <= masterActive;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            newCpuPresent <= 1'h0;
        end else if (ce && !addrStrobeN) begin
            newCpuPresent <= 1'h1;
        end
    end

    // =====================================================================
    // Command strobes and pin direction
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ioReadCmdN   <= STROBE_IDLE;
            ioWriteCmdN  <= STROBE_IDLE;
            memReadCmdN  <= STROBE_IDLE;
            memWriteCmdN <= STROBE_IDLE;
            intAckN      <= STROBE_IDLE;
        end else if (ce) begin
            ioReadCmdN   <= !((state_next == ST_TC) && (kindSel == K_IO_RD));
            ioWriteCmdN  <= !((state_next == ST_TC) && (kindSel == K_IO_WR));
            memReadCmdN  <= !((state_next == ST_TC) && (kindSel == K_MRD));
            memWriteCmdN <= !((state_next == ST_TC) && (kindSel == K_MWR));
            intAckN      <= !((state_next == ST_TC) && (kindSel == K_IACK));
        end
    end

    // Drivers released while a master owns the bus so it can drive the lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdOeN             <= OE_RELEASED;
            latchedAddrBit0OeN <= OE_RELEASED;
            addrBit20OeN       <= OE_RELEASED;
        end else if (ce) begin
            cmdOeN             <= masterActive;
            latchedAddrBit0OeN <= masterActive;
            addrBit20OeN       <= masterActive;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            masterCmdSeen <= 1'h0;
        end else if (ce) begin
            masterCmdSeen <= masterActive && (!ioReadCmdIn || !ioWriteCmdIn
                                              || !memReadCmdIn || !memWriteCmdIn);
        end
    end

    // =====================================================================
    // Address latch strobe
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaPrev_reg     <= 1'h0;
            refreshPrev_reg <= 1'h1;
        end else if (ce) begin
            dmaPrev_reg     <= dmaActive;
            refreshPrev_reg <= refreshN;
        end
    end

    // Pulse ends on the next edge; bus devices capture on that falling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrLatchEnable <= ALE_IDLE;
        end else if (ce) begin
            addrLatchEnable <= (state_next == ST_TS)
                               || (dmaActive && !dmaPrev_reg)
                               || (!refreshN && refreshPrev_reg);
        end
    end

    // =====================================================================
    // Byte lanes and latched address bit 0
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latchedAddrBit0 <= 1'h0;
        end else if (ce && (state_reg == ST_IDLE) && (state_next == ST_TS)) begin
            latchedAddrBit0 <= cpuAddrLow[0];
        end
    end

    assign laneBit0 = masterActive ? latchedAddrBit0In : latchedAddrBit0;

    cpbcc_lane_decode u_lane (
        .highByteEnableN (highByteEnableN),
        .addrBit0        (laneBit0),
        .wordXfer        (laneWord),
        .oddByte         (laneOdd),
        .evenByte        (laneEven)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wordXfer <= 1'h0;
            oddByte  <= 1'h0;
            evenByte <= 1'h0;
        end else if (ce) begin
            wordXfer <= laneWord;
            oddByte  <= laneOdd;
            evenByte <= laneEven;
        end
    end

    // =====================================================================
    // Address line 20 gating
    // =====================================================================
    // Port write takes effect when the write cycle completes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            altGate_reg <= ALT_GATE_RESET;
        end else if (ce && (state_reg == ST_TC) && (state_next == ST_DONE)
                     && (kind_reg == K_IO_WR) && (cpuAddrLow == ALT_GATE_PORT)) begin
            altGate_reg <= cpuDataBit1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrBit20 <= 1'h0;
        end else if (ce) begin
            addrBit20 <= cpuAddrBit20 && (kbcAddr20Gate || altGate_reg);
        end
    end

    // =====================================================================
    // Command buffer enable
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdBufferEnableN <= CMDBUF_IDLE;
        end else if (ce) begin
            if (dmaActive || !refreshN) begin
                cmdBufferEnableN <= 1'h0;
            end else if (inCycle && isIo) begin
                cmdBufferEnableN <= coprocHit || onboardClaim;
            end else if (inCycle && isMem) begin
                cmdBufferEnableN <= videoClaim;
            end else begin
                cmdBufferEnableN <= CMDBUF_IDLE;
            end
        end
    end

    // =====================================================================
    // Transceiver direction
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xcvrDirection <= XCVR_IDLE;
        end else if (ce) begin
            if (dmaActive) begin
                xcvrDirection <= !dmaMemCycle;
            end else if (inCycle && ((kindSel == K_IACK) || (kindSel == K_MRD)
                                     || (kindSel == K_IO_RD))) begin
                xcvrDirection <= 1'h0;
            end else begin
                xcvrDirection <= XCVR_IDLE;
            end
        end
    end

endmodule : cpbcc_bus_control

// [cpbcc_chk.sv]
// Port-level assertions for the bus command control block
`timescale 1ns/100ps
module cpbcc_chk (
    input wire logic clk,              // Clock
    input wire logic rst,              // Reset
    input wire logic sysReadyN,        // Ready
    input wire logic addrLatchEnable,  // Latch strobe
    input wire logic ioReadCmdN,       // I/O read
    input wire logic memReadCmdN,      // Mem read
    input wire logic memWriteCmdN,     // Mem write
    input wire logic intAckN,          // Acknowledge
    input wire logic xcvrDirection,    // Direction
    input wire logic zeroWaitN,        // Zero wait
    input wire logic masterN,          // Master
    input wire logic dmaActive,        // DMA
    input wire logic refreshN,         // Refresh
    input wire logic cmdBufferEnableN, // Buffer enable
    input wire logic kbcAddr20Gate,    // Gate
    input wire logic cpuAddrBit20,     // Bit 20 in
    input wire logic addrBit20         // Bit 20 out
);
    // ============================================================
    // Assertions, all on the one clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ready_pulse_a: assert property (!sysReadyN |=> sysReadyN) else $error("Ready too long");
    ale_pulse_a: assert property (addrLatchEnable |=> !addrLatchEnable) else $error("ALE");
    ale_lead_a: assert property (
        $fell(memReadCmdN) |-> $past(addrLatchEnable)) else $error("No ALE");
    zero_wait_a: assert property (
        $fell(memReadCmdN) && !zeroWaitN |=> !sysReadyN) else $error("Waits");
    read_dir_a: assert property (
        !(ioReadCmdN && memReadCmdN && intAckN) |-> !xcvrDirection) else $error("Read direction");
    write_dir_a: assert property (
        masterN && !dmaActive && !memWriteCmdN |-> xcvrDirection) else $error("Write direction");
    bit20_gate_a: assert property (
        kbcAddr20Gate && cpuAddrBit20 |=> addrBit20) else $error("Gate");
    bit20_off_a: assert property (!cpuAddrBit20 |=> !addrBit20) else $error("Bit 20 high");
    buf_dma_a: assert property (
        (dmaActive || !refreshN)[*3] |-> !cmdBufferEnableN) else $error("Buf");
endmodule : cpbcc_chk
bind cpbcc_bus_control cpbcc_chk cpbcc_chk_inst (.*);

// [cpbcc_dev_model.sv]
// Behavioural expansion-bus device: channel ready and address capture
`timescale 1ns/100ps
module cpbcc_dev_model #(parameter int SLOW = 8) (
    input  wire logic clk,    // Clock
    input  wire logic slow,   // Stretch commands
    input  wire logic cmdLow, // Any command pin low
    input  wire logic ale,    // Latch strobe
    input  wire logic bit0,   // Latched bit 0 pin
    output logic      ready,  // Channel ready
    output logic      capBit0 // Captured bit 0
);
    int cnt = 0;
    always @(posedge clk) cnt <= cmdLow ? cnt + 1 : 0;
    assign ready = !slow || cnt >= SLOW;
    always @(negedge ale) capBit0 <= bit0;
endmodule : cpbcc_dev_model

// [tb_top.sv]
// Self-checking bench for the bus command control block
`timescale 1ns/100ps
module tb_top
    import cpbcc_pkg::*;
;
    localparam int SLOW = 8;
    localparam int NW   = 3 + WAITS_NARROW;
    logic clk = 0, rst = 1, ce = 1, addrStrobeN = 1, memIoSel = 0, dataCodeSel = 0, writeRead = 0;
    logic cpuAddrBit20 = 0, cpuDataBit1 = 0, highByteEnableN = 1, kbcAddr20Gate = 0, zeroWaitN = 1;
    logic ioWideSelectN = 1, memWideSelectN = 1, masterN = 1, dmaActive = 0, refreshN = 1;
    logic coprocHit = 0, videoEnabled = 0, videoRomHit = 0, videoRamHit = 0, slow = 0;
    logic [15:0] cpuAddrLow = 16'h0000;
    logic [ONBOARD_COUNT-1:0] onboardEnable = 5'h00, onboardIoHit = 5'h00;
    logic [3:0] mstCmd = 4'hF;
    logic [5:0] obs;
    logic sysReadyN, sysReadyOeN, ioReadCmdN, ioWriteCmdN, memReadCmdN, memWriteCmdN, cmdOeN;
    logic latchedAddrBit0, latchedAddrBit0OeN, addrBit20, addrBit20OeN, intAckN, capBit0;
    logic addrLatchEnable, cmdBufferEnableN, xcvrDirection, wordXfer, oddByte, evenByte;
    logic masterCmdSeen, newCpuPresent, ioChannelReady, ioReadCmdIn, ioWriteCmdIn, memReadCmdIn;
    logic memWriteCmdIn, latchedAddrBit0In, cmdLow, bufLow, aleSeen;
    int lat, error_cnt = 0, total_checks = 0;
    // Released pins read as the external master's drive or their pull-ups
    assign {ioReadCmdIn, ioWriteCmdIn, memReadCmdIn, memWriteCmdIn} = cmdOeN ? mstCmd :
        {ioReadCmdN, ioWriteCmdN, memReadCmdN, memWriteCmdN};
    assign latchedAddrBit0In = latchedAddrBit0OeN ? 1'h1 : latchedAddrBit0;
    assign cmdLow = !(&{ioReadCmdIn, ioWriteCmdIn, memReadCmdIn, memWriteCmdIn});
    cpbcc_bus_control cpbcc_bus_control_inst (.*);
    cpbcc_dev_model #(.SLOW(SLOW)) cpbcc_dev_model_inst (.clk(clk), .slow(slow), .cmdLow(cmdLow),
        .ale(addrLatchEnable), .bit0(latchedAddrBit0In), .ready(ioChannelReady), .capBit0(capBit0));
    initial forever #5 clk = ~clk;
    // ============================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // One processor cycle; eb[1] set means the buffer enable is not judged
    task automatic run(input logic [2:0] st, input logic [15:0] a, input logic [5:0] eo,
                       input logic [1:0] eb, input int el);
        {obs, bufLow, lat} = '0;
        {memIoSel, dataCodeSel, writeRead} = st;
        cpuAddrLow = a;
        addrStrobeN = 0;
        do begin
            @(negedge clk);
            addrStrobeN = 1;
            lat++;
            obs |= ~{intAckN, ioReadCmdN, ioWriteCmdN, memReadCmdN, memWriteCmdN, xcvrDirection};
            bufLow |= !cmdBufferEnableN;
        end while (sysReadyN !== 1'b0 && lat < 40);
        if (sysReadyN !== 1'b0) begin
            error_cnt++;
            test_done();
        end
        @(negedge clk);
        chk(obs, eo);
        chk(lat, el);
        if (!eb[1]) chk(bufLow, eb[0]);
    endtask : run
    task automatic hold3;
        aleSeen = 0;
        repeat (3) @(negedge clk) aleSeen |= addrLatchEnable;
    endtask : hold3
    task automatic a20(input logic e);
        repeat (2) @(negedge clk);
        chk(addrBit20, e);
    endtask : a20
    // ============================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 0;
        chk(newCpuPresent, 0);
        run(3'h0, 16'h0020, 6'h21, 2'h2, NW);
        run(3'h0, 16'h0020, 6'h21, 2'h2, NW);
        run(3'h2, 16'h0060, 6'h11, 2'h1, NW);
        run(3'h3, 16'h0061, 6'h08, 2'h1, NW);
        run(3'h4, 16'h1000, 6'h05, 2'h1, NW);
        run(3'h6, 16'h1002, 6'h05, 2'h1, NW);
        run(3'h7, 16'h1001, 6'h02, 2'h1, NW);
        run(3'h5, 16'h0002, 6'h00, 2'h2, 2);
        run(3'h1, 16'h0000, 6'h00, 2'h2, 2);
        chk(newCpuPresent, 1);
        $display("Test cycle kinds done");
        ioWideSelectN = 0;
        run(3'h2, 16'h0300, 6'h11, 2'h1, 3 + WAITS_WIDE);
        {ioWideSelectN, memWideSelectN} = 2'h2;
        run(3'h7, 16'h2000, 6'h02, 2'h1, 3 + WAITS_WIDE);
        {memWideSelectN, zeroWaitN} = 2'h2;
        run(3'h4, 16'h2000, 6'h05, 2'h1, 3 + WAITS_ZERO);
        {zeroWaitN, slow} = 2'h3;
        run(3'h4, 16'h2000, 6'h05, 2'h1, SLOW + 3);
        slow = 0;
        $display("Test wait states done");
        for (int i = 0; i < ONBOARD_COUNT; i++) begin
            onboardEnable = 5'h01 << i;
            onboardIoHit = onboardEnable;
            run(3'h2, 16'h03F0, 6'h11, 2'h0, NW);
        end
        onboardEnable = 5'h00;
        run(3'h2, 16'h03F0, 6'h11, 2'h1, NW);
        coprocHit = 1;
        run(3'h3, 16'h00F0, 6'h08, 2'h0, NW);
        {coprocHit, videoRomHit} = 2'h1;
        run(3'h4, 16'h0000, 6'h05, 2'h1, NW);
        videoEnabled = 1;
        run(3'h4, 16'h0000, 6'h05, 2'h0, NW);
        {videoRomHit, videoRamHit} = 2'h1;
        run(3'h7, 16'h8000, 6'h02, 2'h0, NW);
        {videoEnabled, videoRamHit} = 2'h0;
        $display("Test buffer claims done");
        for (int j = 0; j < 4; j++) begin
            highByteEnableN = j[1];
            run(3'h4, {15'h0, j[0]}, 6'h05, 2'h1, NW);
            chk({wordXfer, oddByte, evenByte}, 3'h4 >> j);
            chk({latchedAddrBit0, capBit0}, {2{j[0]}});
        end
        $display("Test byte lanes done");
        cpuAddrBit20 = 1;
        a20(0);
        kbcAddr20Gate = 1;
        a20(1);
        {kbcAddr20Gate, cpuDataBit1} = 2'h1;
        run(3'h3, ALT_GATE_PORT, 6'h08, 2'h2, NW);
        a20(1);
        cpuAddrBit20 = 0;
        a20(0);
        {cpuAddrBit20, cpuDataBit1} = 2'h2;
        run(3'h3, ALT_GATE_PORT, 6'h08, 2'h2, NW);
        a20(0);
        $display("Test address bit 20 done");
        dmaActive = 1;
        hold3();
        chk({aleSeen, cmdBufferEnableN}, 2'h2);
        {dmaActive, refreshN} = 2'h0;
        hold3();
        chk({aleSeen, cmdBufferEnableN}, 2'h2);
        refreshN = 1;
        hold3();
        {masterN, dmaActive, mstCmd} = 6'h1D;
        hold3();
        chk({cmdOeN, addrBit20OeN, latchedAddrBit0OeN, sysReadyOeN}, 4'hF);
        chk({masterCmdSeen, xcvrDirection}, 2'h2);
        $display("Test DMA and master done");
        test_done();
    end
endmodule : tb_top
